// >>> hdl/eth_ctrl_pkg.sv
// Constants and types for the Ethernet MAC control block.
// Assumes a single 10 MHz clock and synchronous active-low reset.
//
// Notes on behaviour
// - Three writable control groups: transmit, receive, timestamp.
// - Transmit group holds full duplex, auto FCS and short-frame pad.
// - Receive group holds bad-FCS reject, multicast accept, promiscuous.
// - Timestamp enable routes tx/rx event status to timer capture.
// - Bad-FCS frames not counted or marked last when rejection is on; their bytes still reach the FIFO.
// - Promiscuous mode accepts every frame.
// - Multicast frames accepted only when enabled or promiscuous.
// - Programmable station address filters frames and reads back.
// - Configuration bits read back as programmed.
// - Disable stops tx and rx and flushes receive FIFO.
// - PHY auto-negotiates from reset; software may override.
// - PHY register read and write access by register number.
// - Status shows tx space available and rx frame waiting.
// - Interrupt sources individually enabled, readable and clearable.
// - Operates at 10 and 100 Mbit/s twisted pair.
// - Enable turns on tx and rx and empties receive FIFO.
// - Only enabled sources drive the interrupt output.
// - Address filter applies only when not promiscuous.
`default_nettype none
package eth_ctrl_pkg;
    // -----------------------------------------------------------------
    // Configuration bit positions
    // -----------------------------------------------------------------
    localparam int CFG_W       = 7;
    localparam int CFG_TSEN    = 0;
    localparam int CFG_BADFCS  = 1;
    localparam int CFG_PROMISC = 2;
    localparam int CFG_MCAST   = 3;
    localparam int CFG_DUPLEX  = 4;
    localparam int CFG_AUTOFCS = 5;
    localparam int CFG_PAD     = 6;
    localparam logic [6:0] CFG_RESET = 7'h00;
    // -----------------------------------------------------------------
    // Interrupt source positions
    // -----------------------------------------------------------------
    localparam int IRQ_W    = 7;
    localparam int IRQ_PHY  = 0;
    localparam int IRQ_MDIO = 1;
    localparam int IRQ_RXER = 2;
    localparam int IRQ_RXOF = 3;
    localparam int IRQ_TX   = 4;
    localparam int IRQ_TXER = 5;
    localparam int IRQ_RX   = 6;
    // -----------------------------------------------------------------
    // Widths, counts and PHY access timing
    // -----------------------------------------------------------------
    localparam int ADDR_W       = 48;
    localparam int DATA_W       = 8;
    localparam int PHY_REG_W    = 5;
    localparam int PHY_DATA_W   = 16;
    localparam int PHY_ACC_NS   = 6400;
    localparam int CLK_NS       = 100;
    localparam int PHY_ACC_CYC  = (PHY_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int PKT_W        = 4;
    localparam logic [3:0] PKT_MAX = 4'hF;
    localparam logic [47:0] ADDR_RESET = 48'h0;
    localparam logic [6:0]  PHY_ACC_CNT = 7'(PHY_ACC_CYC);

    typedef enum logic [1:0] {PHY_IDLE, PHY_BUSY} phy_state_t;
    typedef enum logic [1:0] {RX_HDR, RX_BODY, RX_DROP} rx_state_t;
endpackage
`default_nettype wire

// >>> hdl/eth_skid_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module eth_skid_buf (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       flush,
    input  wire logic [8:0] in_data,
    input  wire logic       in_valid,
    output logic            in_ready,
    output logic [8:0]      out_data,
    output logic            out_valid,
    input  wire logic       out_ready
);
    logic [8:0] mem_r [2];
    logic       wr_ptr_r;
    logic       rd_ptr_r;
    logic [1:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // -----------------------------------------------------------------
    // Status from occupancy count
    // -----------------------------------------------------------------
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];

    // Storage and pointers
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            if (push) wr_ptr_r <= ~wr_ptr_r;
            if (pop)  rd_ptr_r <= ~rd_ptr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem_r[wr_ptr_r] <= in_data;
    end
endmodule // eth_skid_buf
`default_nettype wire

// >>> hdl/eth_mac_ctrl.sv
// Control and configuration logic of an Ethernet MAC with on-chip PHY.
// Assumes the frame path delivers bytes with start/end/fcs-error marks.
`timescale 1ns/1ps
`default_nettype none
module eth_mac_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Configuration write and readback
    input  wire logic        cfg_wr,
    input  wire logic [6:0]  cfg_wdata,
    output logic [6:0]       cfg_rdata,
    input  wire logic        mac_enable,
    input  wire logic        addr_wr,
    input  wire logic [47:0] addr_wdata,
    output logic [47:0]      addr_rdata,
    output logic             tx_on,
    output logic             rx_on,
    output logic             full_duplex_enable,
    output logic             auto_fcs_enable,
    output logic             short_frame_pad_enable,
    output logic             speed_100,
    // Interrupt control
    input  wire logic [6:0]  irq_mask_wdata,
    input  wire logic        irq_mask_wr,
    input  wire logic [6:0]  irq_clear,
    input  wire logic [6:0]  irq_event,
    output logic [6:0]       irq_raw,
    output logic [6:0]       irq_masked,
    output logic             irq,
    output logic [1:0]       timer_capture_input,
    // PHY register access
    input  wire logic        phy_req,
    input  wire logic        phy_write,
    input  wire logic [4:0]  phy_reg,
    input  wire logic [15:0] phy_wdata,
    output logic [15:0]      phy_rdata,
    output logic             phy_busy,
    output logic             phy_mgmt_req,
    output logic             phy_mgmt_we,
    output logic [4:0]       phy_mgmt_reg,
    output logic [15:0]      phy_mgmt_wdata,
    input  wire logic [15:0] phy_mgmt_rdata,
    input  wire logic        phy_link_100,
    // Receive byte stream from the line side
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic        rx_fcs_bad,
    // Accepted bytes towards the receive FIFO
    output logic [7:0]       rxf_data,
    output logic             rxf_last,
    output logic             rxf_valid,
    input  wire logic        rxf_ready,
    output logic             rx_frame_avail,
    input  wire logic        rx_frame_taken,
    // Transmit FIFO status
    input  wire logic        tx_fifo_free,
    output logic             tx_space_avail
);
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [6:0]  cfg_r;
    logic [47:0] addr_r;
    logic        en_r;
    logic        flush_r;
    logic [6:0]  irq_raw_r;
    logic [6:0]  irq_en_r;
    logic        irq_r;
    logic [1:0]  tcap_r;
    logic        l100_s1_r;
    logic        l100_s2_r;
    logic        txf_s1_r;
    logic        txf_s2_r;
    logic        txsp_r;
    logic        spd_r;
    eth_ctrl_pkg::phy_state_t phy_st_r;
    logic [6:0]  phy_cnt_r;
    logic        phy_we_r;
    logic [4:0]  phy_reg_r;
    logic [15:0] phy_wd_r;
    logic [15:0] phy_rd_r;
    eth_ctrl_pkg::rx_state_t rx_st_r;
    logic [2:0]  rx_idx_r;
    logic        rx_mc_r;
    logic        rx_hit_r;
    logic [3:0]  pkt_cnt_r;
    logic        pkt_r;

    // Address byte picker, used for the filter compare
    function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                             input logic [2:0] i);
        addr_byte = a[8'(47 - 8 * int'(i)) -: 8];
    endfunction

    // -----------------------------------------------------------------
    // Configuration, enable and address
    // -----------------------------------------------------------------
    wire promisc  = cfg_r[eth_ctrl_pkg::CFG_PROMISC];
    wire en_edge  = mac_enable != en_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r   <= eth_ctrl_pkg::CFG_RESET;
            addr_r  <= eth_ctrl_pkg::ADDR_RESET;
            en_r    <= 1'b0;
            flush_r <= 1'b1;
        end else begin
            if (cfg_wr) cfg_r <= cfg_wdata;
            if (addr_wr) addr_r <= addr_wdata;
            en_r    <= mac_enable;
            flush_r <= en_edge;
        end
    end
    assign cfg_rdata  = cfg_r;
    assign addr_rdata = addr_r;
    assign tx_on      = en_r;
    assign rx_on      = en_r;
    assign full_duplex_enable     = cfg_r[eth_ctrl_pkg::CFG_DUPLEX];
    assign auto_fcs_enable        = cfg_r[eth_ctrl_pkg::CFG_AUTOFCS];
    assign short_frame_pad_enable = cfg_r[eth_ctrl_pkg::CFG_PAD];

    // -----------------------------------------------------------------
    // Line rate follows the PHY's negotiated link, synchronised
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            l100_s1_r <= 1'b0;
            l100_s2_r <= 1'b0;
            spd_r     <= 1'b0;
            txf_s1_r  <= 1'b0;
            txf_s2_r  <= 1'b0;
            txsp_r    <= 1'b0;
        end else begin
            l100_s1_r <= phy_link_100;
            l100_s2_r <= l100_s1_r;
            spd_r     <= l100_s2_r;
            txf_s1_r  <= tx_fifo_free;
            txf_s2_r  <= txf_s1_r;
            txsp_r    <= txf_s2_r && en_r;
        end
    end
    assign speed_100      = spd_r;
    assign tx_space_avail = txsp_r;

    // -----------------------------------------------------------------
    // Interrupt sources: set wins over clear, masked onto one output
    // -----------------------------------------------------------------
    wire [6:0] irq_nxt = (irq_raw_r & ~irq_clear) | irq_event;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_raw_r <= 7'h00;
            irq_en_r  <= 7'h00;
            irq_r     <= 1'b0;
            tcap_r    <= 2'h0;
        end else begin
            irq_raw_r <= irq_nxt;
            if (irq_mask_wr) irq_en_r <= irq_mask_wdata;
            irq_r     <= |(irq_nxt & irq_en_r);
            tcap_r    <= cfg_r[eth_ctrl_pkg::CFG_TSEN] ?
                         {irq_nxt[eth_ctrl_pkg::IRQ_RX],
                          irq_nxt[eth_ctrl_pkg::IRQ_TX]} : 2'h0;
        end
    end
    assign irq_raw    = irq_raw_r;
    assign irq_masked = irq_raw_r & irq_en_r;
    assign irq        = irq_r;
    assign timer_capture_input = tcap_r;

    // -----------------------------------------------------------------
    // PHY register access: one request at a time, fixed access time
    // -----------------------------------------------------------------
    wire phy_start = phy_req && (phy_st_r == eth_ctrl_pkg::PHY_IDLE);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phy_st_r  <= eth_ctrl_pkg::PHY_IDLE;
            phy_cnt_r <= 7'h00;
            phy_we_r  <= 1'b0;
            phy_reg_r <= 5'h00;
            phy_wd_r  <= 16'h0000;
            phy_rd_r  <= 16'h0000;
        end else begin
            unique case (phy_st_r)
                eth_ctrl_pkg::PHY_IDLE: begin
                    if (phy_start) begin
                        phy_st_r  <= eth_ctrl_pkg::PHY_BUSY;
                        phy_cnt_r <= eth_ctrl_pkg::PHY_ACC_CNT;
                        phy_we_r  <= phy_write;
                        phy_reg_r <= phy_reg;
                        phy_wd_r  <= phy_wdata;
                    end
                end
                eth_ctrl_pkg::PHY_BUSY: begin
                    phy_cnt_r <= phy_cnt_r - 7'h01;
                    if (phy_cnt_r == 7'h01) begin
                        phy_st_r <= eth_ctrl_pkg::PHY_IDLE;
                        if (!phy_we_r) phy_rd_r <= phy_mgmt_rdata;
                    end
                end
                default: phy_st_r <= eth_ctrl_pkg::PHY_IDLE;
            endcase
        end
    end
    assign phy_busy       = (phy_st_r == eth_ctrl_pkg::PHY_BUSY);
    assign phy_mgmt_req   = phy_busy;
    assign phy_mgmt_we    = phy_we_r;
    assign phy_mgmt_reg   = phy_reg_r;
    assign phy_mgmt_wdata = phy_wd_r;
    assign phy_rdata      = phy_rd_r;

    // -----------------------------------------------------------------
    // Receive filter: destination check over first six bytes
    // -----------------------------------------------------------------
    logic       buf_ready;
    wire        rx_in    = rx_valid && en_r;
    wire [2:0]  idx      = rx_sof ? 3'h0 : rx_idx_r;
    // Past the address the index parks at six so the verdict is taken once
    wire        hdr_past = !rx_sof && (rx_idx_r == 3'h6);
    wire        byte_hit = (rx_byte == addr_byte(addr_r,
                                                 hdr_past ? 3'h5 : idx));
    wire        hit_nxt  = (rx_sof ? 1'b1 : rx_hit_r) && byte_hit;
    wire        mc_nxt   = rx_sof ? rx_byte[0] : rx_mc_r;
    wire        accept   = promisc ||
                           (!promisc && hit_nxt) ||
                           (mc_nxt && cfg_r[eth_ctrl_pkg::CFG_MCAST]);
    wire        hdr_done = (idx == 3'h5);
    wire        drop_fcs = rx_eof && rx_fcs_bad &&
                           cfg_r[eth_ctrl_pkg::CFG_BADFCS];
    wire        in_body  = rx_sof || (rx_st_r != eth_ctrl_pkg::RX_DROP);
    wire        fwd      = rx_in && in_body && buf_ready;
    wire        frame_in = fwd && rx_eof && !drop_fcs;

    always_ff @(posedge clk) begin
        if (!rst_n || flush_r) begin
            rx_st_r  <= eth_ctrl_pkg::RX_HDR;
            rx_idx_r <= 3'h0;
            rx_hit_r <= 1'b0;
            rx_mc_r  <= 1'b0;
        end else if (rx_in) begin
            rx_idx_r <= hdr_past ? 3'h6 : idx + 3'h1;
            rx_hit_r <= hdr_past ? rx_hit_r : hit_nxt;
            rx_mc_r  <= mc_nxt;
            if (rx_eof)
                rx_st_r <= eth_ctrl_pkg::RX_HDR;
            else if (hdr_done && !accept)
                rx_st_r <= eth_ctrl_pkg::RX_DROP;
            else if (!buf_ready && in_body)
                rx_st_r <= eth_ctrl_pkg::RX_DROP;
            else if (rx_sof)
                rx_st_r <= eth_ctrl_pkg::RX_BODY;
        end
    end

    // Two-entry buffer on the path towards the receive FIFO
    eth_skid_buf u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (flush_r),
        .in_data   ({rx_eof && !drop_fcs, rx_byte}),
        .in_valid  (fwd),
        .in_ready  (buf_ready),
        .out_data  ({rxf_last, rxf_data}),
        .out_valid (rxf_valid),
        .out_ready (rxf_ready)
    );

    // -----------------------------------------------------------------
    // Count of whole frames waiting in the receive FIFO
    // -----------------------------------------------------------------
    wire take = rx_frame_taken && (pkt_cnt_r != 4'h0);
    wire add  = frame_in && (pkt_cnt_r != eth_ctrl_pkg::PKT_MAX);
    always_ff @(posedge clk) begin
        if (!rst_n || flush_r) begin
            pkt_cnt_r <= 4'h0;
            pkt_r     <= 1'b0;
        end else begin
            pkt_cnt_r <= pkt_cnt_r + {3'h0, add} - {3'h0, take};
            pkt_r     <= (pkt_cnt_r + {3'h0, add} - {3'h0, take}) != 4'h0;
        end
    end
    assign rx_frame_avail = pkt_r;
endmodule // eth_mac_ctrl
`default_nettype wire

// >>> test/eth_mac_ctrl_properties.sv
// Port-level assertions for the MAC control block.
// Assumes bind onto eth_mac_ctrl, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module eth_mac_ctrl_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cfg_wr,
    input wire logic [6:0]  cfg_wdata,
    input wire logic [6:0]  cfg_rdata,
    input wire logic        mac_enable,
    input wire logic        addr_wr,
    input wire logic [47:0] addr_wdata,
    input wire logic [47:0] addr_rdata,
    input wire logic        tx_on,
    input wire logic        rx_on,
    input wire logic [6:0]  irq_event,
    input wire logic [6:0]  irq_raw,
    input wire logic [6:0]  irq_masked,
    input wire logic        irq,
    input wire logic [1:0]  timer_capture_input,
    input wire logic        phy_req,
    input wire logic [4:0]  phy_reg,
    input wire logic        phy_busy,
    input wire logic [4:0]  phy_mgmt_reg,
    input wire logic        rx_frame_avail,
    input wire logic        rxf_valid,
    input wire logic        rxf_ready,
    input wire logic        rxf_last
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // Configuration and address
    // ---------------------------------------------------------------
    cfg_readback_a: assert property (
        cfg_wr |=> cfg_rdata == $past(cfg_wdata)) else $error("cfg readback");
    addr_readback_a: assert property (
        addr_wr |=> addr_rdata == $past(addr_wdata)) else $error("addr readback");
    enable_follow_a: assert property (
        ##1 (tx_on == $past(mac_enable) && rx_on == $past(mac_enable)))
        else $error("tx or rx enable lag");
    enable_flush_a: assert property (
        mac_enable != $past(mac_enable) |-> ##[1:3] (!rx_frame_avail && !rxf_valid))
        else $error("receive path not flushed");

    // ---------------------------------------------------------------
    // Interrupts and timestamp routing
    // ---------------------------------------------------------------
    irq_sticky_a: assert property (
        irq_event != 7'h00 |=> (irq_raw & $past(irq_event)) == $past(irq_event))
        else $error("event not latched");
    irq_masked_a: assert property (
        (irq_masked & ~irq_raw) == 7'h00) else $error("masked outside raw");
    ts_route_a: assert property (
        (!cfg_rdata[0] && !$past(cfg_rdata[0])) |-> timer_capture_input == 2'h0)
        else $error("capture without enable");

    // ---------------------------------------------------------------
    // PHY access
    // ---------------------------------------------------------------
    phy_take_a: assert property (
        phy_req && !phy_busy |=> phy_busy && phy_mgmt_reg == $past(phy_reg))
        else $error("phy request not taken");
    phy_length_a: assert property (
        $rose(phy_busy) |-> ##63 (phy_busy ##1 !phy_busy)) else $error("phy length");

    // Main scenarios reached
    cover property (rxf_valid && rxf_ready && rxf_last);
    cover property ($fell(phy_busy));
    cover property ($rose(irq));
endmodule // eth_mac_ctrl_properties

bind eth_mac_ctrl eth_mac_ctrl_properties chk_u (.clk, .rst_n, .cfg_wr,
    .cfg_wdata, .cfg_rdata, .mac_enable, .addr_wr, .addr_wdata, .addr_rdata,
    .tx_on, .rx_on, .irq_event, .irq_raw, .irq_masked, .irq,
    .timer_capture_input, .phy_req, .phy_reg, .phy_busy, .phy_mgmt_reg,
    .rx_frame_avail, .rxf_valid, .rxf_ready, .rxf_last);
`default_nettype wire

// >>> test/eth_phy_model.sv
// Behavioural PHY: management register file and link speed.
// Assumes the controller holds mgmt_req for the whole access.
`timescale 1ns/1ps
`default_nettype none
module eth_phy_model #(
    parameter int SPEED_BIT = 13
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mgmt_req,
    input  wire logic        mgmt_we,
    input  wire logic [4:0]  reg_num,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic             link_100
);
    logic [15:0] regs_r [32];
    logic [15:0] last_r;

    // Reset comes up at 100 Mbit/s; writes override it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++)
                regs_r[i] <= 16'h0000;
            regs_r[0] <= 16'h0001 << SPEED_BIT;
        end else if (mgmt_req && mgmt_we) begin
            regs_r[reg_num] <= wdata;
        end
    end

    // Data line shows garbage outside an access
    always_ff @(posedge clk)
        if (mgmt_req)
            last_r <= regs_r[reg_num];
    assign rdata    = mgmt_req ? regs_r[reg_num] : ~last_r;
    assign link_100 = regs_r[0][SPEED_BIT];
endmodule // eth_phy_model
`default_nettype wire

// >>> test/ethernet_mac_control_tb_top.sv
// Self-checking bench for eth_mac_ctrl with a PHY model.
// Assumes inputs change on the falling edge of a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ethernet_mac_control_tb_top;
    logic clk = 0, rst_n = 0, cfg_wr = 0, mac_enable = 0, addr_wr = 0;
    logic irq_mask_wr = 0, phy_req = 0, phy_write = 0, rx_valid = 0;
    logic rx_sof = 0, rx_eof = 0, rx_fcs_bad = 0, rxf_ready = 1;
    logic rx_frame_taken = 0, tx_fifo_free = 0, hold_low = 0, expect_bytes = 0;
    logic [6:0] cfg_wdata = 0, irq_mask_wdata = 0, irq_clear = 0, irq_event = 0;
    logic [47:0] addr_wdata = 0, addr_rdata;
    logic [4:0] phy_reg = 0, phy_mgmt_reg;
    logic [15:0] phy_wdata = 0, phy_rdata, phy_mgmt_wdata, phy_mgmt_rdata;
    logic [15:0] rnd = 16'h0006, pd;
    logic [7:0] rx_byte = 0, rxf_data;
    logic [6:0] cfg_rdata, irq_raw, irq_masked;
    logic [1:0] timer_capture_input;
    logic tx_on, rx_on, full_duplex_enable, auto_fcs_enable, irq, speed_100;
    logic short_frame_pad_enable, phy_busy, phy_mgmt_req, phy_mgmt_we;
    logic phy_link_100, rxf_last, rxf_valid, rx_frame_avail, tx_space_avail;
    logic [8:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    localparam logic [47:0] STA = 48'h021122334455, OTH = 48'h02AABBCCDDEE;
    localparam logic [47:0] MC = 48'h01005E000001;
    logic [47:0] dsts[7] = '{STA, OTH, MC, MC, OTH, STA, STA};
    logic [6:0]  cfgs[7] = '{7'h70, 7'h00, 7'h00, 7'h08, 7'h04, 7'h02, 7'h00};
    logic        bads[7] = '{0, 0, 0, 0, 0, 1, 1};
    logic        oks[7]  = '{1, 0, 0, 1, 1, 0, 1};

    eth_mac_ctrl dut_u (.clk, .rst_n, .cfg_wr, .cfg_wdata, .cfg_rdata,
        .mac_enable, .addr_wr, .addr_wdata, .addr_rdata, .tx_on, .rx_on,
        .full_duplex_enable, .auto_fcs_enable, .short_frame_pad_enable,
        .speed_100, .irq_mask_wdata, .irq_mask_wr, .irq_clear, .irq_event,
        .irq_raw, .irq_masked, .irq, .timer_capture_input, .phy_req,
        .phy_write, .phy_reg, .phy_wdata, .phy_rdata, .phy_busy, .phy_mgmt_req,
        .phy_mgmt_we, .phy_mgmt_reg, .phy_mgmt_wdata, .phy_mgmt_rdata,
        .phy_link_100, .rx_byte, .rx_valid, .rx_sof, .rx_eof, .rx_fcs_bad,
        .rxf_data, .rxf_last, .rxf_valid, .rxf_ready, .rx_frame_avail,
        .rx_frame_taken, .tx_fifo_free, .tx_space_avail);
    eth_phy_model phy_u (.clk, .rst_n, .mgmt_req(phy_mgmt_req),
        .mgmt_we(phy_mgmt_we), .reg_num(phy_mgmt_reg), .wdata(phy_mgmt_wdata),
        .rdata(phy_mgmt_rdata), .link_100(phy_link_100));

    // Clock, random stream and receiver stalls (never two in a row while hold_low is clear)
    always #50 clk = ~clk;
    always @(negedge clk) begin
        rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        rxf_ready <= !hold_low && (rnd[0] || !rxf_ready);
    end

    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Accepted bytes leave the buffer in order, last one marked
    always @(posedge clk) begin
        if (expect_bytes && rxf_valid === 1'b1 && rxf_ready) begin
            if (exp_q.size() == 0)
                check("rx extra", 1, 0);
            else
                check("rx byte", {rxf_last, rxf_data}, exp_q.pop_front());
        end
    end

    // Disable, configure, enable
    task automatic setup(input logic [6:0] cfg);
        @(negedge clk);
        mac_enable <= 0;
        cfg_wr <= 1;
        cfg_wdata <= cfg;
        @(negedge clk);
        cfg_wr <= 0;
        check("cfg", cfg_rdata, cfg);
        mac_enable <= 1;
        repeat (3) @(negedge clk);
        check("txcfg", {short_frame_pad_enable, auto_fcs_enable,
                        full_duplex_enable}, cfg[6:4]);
        check("on", {tx_on, rx_on, rx_frame_avail}, 3'h6);
    endtask

    // Eight-byte frame, one byte every third cycle
    task automatic send_frame(input logic [47:0] dst, input logic bad,
                              input logic keep);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = (i < 6) ? dst[47 - 8 * i -: 8] : 8'(8'hA0 + i);
            @(negedge clk);
            rx_byte <= b;
            rx_valid <= 1;
            rx_sof <= (i == 0);
            rx_eof <= (i == 7);
            rx_fcs_bad <= bad && (i == 7);
            if (keep)
                exp_q.push_back({i == 7, b});
            @(negedge clk);
            rx_valid <= 0;
            @(negedge clk);
        end
    endtask

    task automatic phy_op(input logic wr, input logic [4:0] r,
                          input logic [15:0] d);
        @(negedge clk);
        phy_req <= 1;
        phy_write <= wr;
        phy_reg <= r;
        phy_wdata <= d;
        @(negedge clk);
        phy_req <= 0;
        check("busy", phy_busy, 1);
        for (int n = 0; n < 100 && phy_busy; n++)
            @(negedge clk);
        check("idle", phy_busy, 0);
    endtask

    initial begin
        #(20000 * 100);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (6) @(negedge clk);
        rst_n <= 1;
        repeat (2) @(negedge clk);
        addr_wr <= 1;
        addr_wdata <= STA;
        @(negedge clk);
        addr_wr <= 0;
        check("addr", addr_rdata, STA);
        check("speed", speed_100, 1);
        for (int k = 0; k < 7; k++) begin
            setup(cfgs[k]);
            expect_bytes = oks[k];
            send_frame(dsts[k], bads[k], oks[k]);
            repeat (6) @(negedge clk);
            check("frame", rx_frame_avail, oks[k]);
            check("drained", exp_q.size(), 0);
            rx_frame_taken <= 1;
            @(negedge clk);
            rx_frame_taken <= 0;
            @(negedge clk);
            check("taken", rx_frame_avail, 0);
        end
        expect_bytes = 0;
        $display("test receive filter done");
        hold_low = 1;
        tx_fifo_free <= 1;
        setup(7'h00);
        send_frame(STA, 0, 0);
        check("space", {tx_space_avail, rxf_valid}, 2'h3);
        mac_enable <= 0;
        repeat (4) @(negedge clk);
        check("flush", {rxf_valid, rx_frame_avail, tx_on, rx_on,
                        tx_space_avail}, 0);
        hold_low = 0;
        $display("test disable flush done");
        setup(7'h01);
        irq_mask_wr <= 1;
        irq_mask_wdata <= 7'h55;
        @(negedge clk);
        irq_mask_wr <= 0;
        for (int i = 0; i < 7; i++) begin
            irq_event <= 7'h01 << i;
            @(negedge clk);
            irq_event <= 0;
            check("raw", irq_raw, 7'h01 << i);
            check("masked", irq_masked, (7'h01 << i) & 7'h55);
            check("irq", irq, (7'h55 >> i) & 1);
            check("ts", timer_capture_input, {i == 6, i == 4});
            irq_clear <= 7'h01 << i;
            @(negedge clk);
            irq_clear <= 0;
            check("clear", {irq, irq_raw, timer_capture_input}, 0);
        end
        $display("test interrupts done");
        phy_op(1, 5'h00, 16'h0000);
        repeat (4) @(negedge clk);
        check("speed10", speed_100, 0);
        pd = rnd;
        phy_op(1, {pd[4:1], 1'b1}, pd);
        phy_op(0, {pd[4:1], 1'b1}, ~pd);
        check("phy read", phy_rdata, pd);
        $display("test phy access done");
        complete_run();
    end
endmodule // ethernet_mac_control_tb_top
`default_nettype wire
